// ==== loop_cfg.sv ====
// Top: loop configuration registers and gain control start/freeze/restart sequencing
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Gain one is high nibble plus low byte
// - Gain two is high nibble plus low byte
// - Attack code n gives two to -(n+1)
// - Decay code n gives two to -(n+2)
// - Restart on channel change, polling, hold exit
// - Freeze mode picks never, an event (RSSI, recognition, sync), or manual
// - Start mode: off, direct, RSSI, recognition
// - Reset values 00 and 42 hexadecimal
// - Freeze delay: strobe over four, times ratio
module loop_cfg
(
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic [7:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr_stb,
    input  wire logic        rd_stb,
    output logic [7:0]       rdata,
    input  wire logic        predec_strobe,
    input  wire logic        rssi_event,
    input  wire logic        sigrec_event,
    input  wire logic        sync_event,
    input  wire logic        channel_change,
    input  wire logic        poll_cfg_start,
    input  wire logic        hold_exit,
    input  wire logic        pll_hold_init_bit,
    input  wire logic        run_mode_slave,
    output logic [11:0]      freq_gain1,
    output logic [11:0]      freq_gain2,
    output logic [3:0]       peak_attack_shift,
    output logic [3:0]       peak_decay_shift,
    output logic             gain_loop_active,
    output logic             gain_loop_frozen
);
    import loop_cfg_pkg::*;

    // Exponent of code zero; each code step halves the factor again
    localparam logic [3:0] ATTACK_BIAS = 4'h1;
    localparam logic [3:0] DECAY_BIAS  = 4'h2;

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [7:0]   gain1_low_byte;
    logic [7:0]   gain1_high_q;
    logic [7:0]   gain2_low_byte;
    logic [7:0]   gain2_high_q;
    logic [7:0]   peak_q;
    logic [7:0]   sf_cfg_q;
    logic [7:0]   ratio_q;
    logic         manual_gain_freeze_cmd;
    logic [7:0]   status;
    logic [2:0]   peak_attack_factor;
    logic [2:0]   peak_decay_factor;
    logic         gain_restart_enable;
    freeze_mode_t gain_freeze_mode;
    start_mode_t  gain_start_mode;
    loop_state_t  state_q;
    loop_state_t  state_d;
    logic         restart;
    logic         start_hit;
    logic         freeze_hit;
    logic         delay_start;
    logic         delay_done;

    // Status for software: frozen in bit 1, active in bit 0
    assign status = {6'h00, gain_loop_frozen, gain_loop_active};

    // Register file and read port
    reg_port u_regs
    (
        .mclk           (mclk),
        .srst           (srst),
        .addr           (addr),
        .wdata          (wdata),
        .wr_stb         (wr_stb),
        .rd_stb         (rd_stb),
        .status         (status),
        .rdata          (rdata),
        .gain1_low_byte (gain1_low_byte),
        .gain1_high_q   (gain1_high_q),
        .gain2_low_byte (gain2_low_byte),
        .gain2_high_q   (gain2_high_q),
        .peak_q         (peak_q),
        .sf_cfg_q       (sf_cfg_q),
        .ratio_q        (ratio_q),
        .man_freeze     (manual_gain_freeze_cmd)
    );

    // Field extraction
    assign peak_attack_factor  = peak_q[ATTACK_MSB:ATTACK_LSB];
    assign peak_decay_factor   = peak_q[DECAY_MSB:DECAY_LSB];
    assign gain_restart_enable = sf_cfg_q[RESTART_BIT];
    assign gain_freeze_mode    = freeze_mode_t'(sf_cfg_q[FREEZE_MSB:FREEZE_LSB]);
    assign gain_start_mode     = start_mode_t'(sf_cfg_q[START_MSB:START_LSB]);

    // Factor code to shift exponent; shared by reset and update paths
    function automatic logic [3:0] shift_of(input logic [2:0] code, input logic [3:0] bias);
        shift_of = {1'b0, code} + bias;
    endfunction

    // ****************************************************************
    // Coefficient outputs
    // ****************************************************************
    // Registered so the outputs come straight from flops
    // Shifts are exponents: the filter divides by two to that power
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            freq_gain1        <= 12'h000;
            freq_gain2        <= 12'h000;
            peak_attack_shift <= shift_of(RST_PEAK_FACT[ATTACK_MSB:ATTACK_LSB], ATTACK_BIAS);
            peak_decay_shift  <= shift_of(RST_PEAK_FACT[DECAY_MSB:DECAY_LSB], DECAY_BIAS);
        end
        else
        begin
            freq_gain1        <= {gain1_high_q[3:0], gain1_low_byte};
            freq_gain2        <= {gain2_high_q[3:0], gain2_low_byte};
            peak_attack_shift <= shift_of(peak_attack_factor, ATTACK_BIAS);
            peak_decay_shift  <= shift_of(peak_decay_factor, DECAY_BIAS);
        end
    end

    // ****************************************************************
    // Gain loop sequencing
    // ****************************************************************
    // Hold exit only counts in slave run mode with the hold init bit set
    // and every restart source needs the enable bit
    assign restart = gain_restart_enable && (channel_change || poll_cfg_start ||
                     (run_mode_slave && pll_hold_init_bit && hold_exit));

    // Start criterion; software should match wake-up level criteria
    always_comb
    begin
        case (gain_start_mode)
            START_DIRECT: start_hit = 1'b1;
            START_RSSI:   start_hit = rssi_event;
            START_SIGREC: start_hit = sigrec_event;
            default:      start_hit = 1'b0;
        endcase
    end

    // Freeze criterion; unused codes above manual never freeze
    always_comb
    begin
        case (gain_freeze_mode)
            FRZ_RSSI:   freeze_hit = rssi_event;
            FRZ_SIGREC: freeze_hit = sigrec_event;
            FRZ_SYNC:   freeze_hit = sync_event;
            FRZ_MANUAL: freeze_hit = manual_gain_freeze_cmd;
            default:    freeze_hit = 1'b0;
        endcase
    end

    // Manual freeze bypasses the delay; event freezes go through it
    assign delay_start = (state_q == LOOP_RUN) && freeze_hit &&
                         (gain_freeze_mode != FRZ_MANUAL);

    // One shared counter times every event freeze
    freeze_delay u_delay
    (
        .mclk   (mclk),
        .srst   (srst),
        .strobe (predec_strobe),
        .start  (delay_start),
        .ratio  (ratio_q),
        .done   (delay_done)
    );

    // Restart is applied last so it wins over a freeze in the same cycle:
    // a channel change with restart enabled must never leave a stale frozen gain behind
    // Start mode off forces idle whatever the loop was doing
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            LOOP_IDLE:
                if (start_hit)
                    state_d = LOOP_RUN;
            LOOP_RUN:
                if (freeze_hit && gain_freeze_mode == FRZ_MANUAL)
                    state_d = LOOP_FROZEN;
                else if (delay_start)
                    state_d = LOOP_DELAY;
            LOOP_DELAY:
                if (delay_done)
                    state_d = LOOP_FROZEN;
                else if (restart)
                    state_d = LOOP_RUN;
            LOOP_FROZEN:
                if (restart || (start_hit && gain_start_mode != START_DIRECT))
                    state_d = LOOP_RUN;
            default:
                state_d = LOOP_IDLE;
        endcase
        if (gain_start_mode == START_OFF)
            state_d = LOOP_IDLE;
        else if (restart && state_q != LOOP_IDLE)
            state_d = LOOP_RUN;
    end

    // State register; reset leaves the loop off
    always_ff @(posedge mclk)
    begin
        if (srst)
            state_q <= LOOP_IDLE;
        else
            state_q <= state_d;
    end

    // Frozen flag tells the gain stage to keep its present setting
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            gain_loop_active <= 1'b0;
            gain_loop_frozen <= 1'b0;
        end
        else
        begin
            gain_loop_active <= (state_d == LOOP_RUN) || (state_d == LOOP_DELAY);
            gain_loop_frozen <= (state_d == LOOP_FROZEN);
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    // Register and coefficient checks
    a_gain1_concat: assert property (@(posedge mclk) disable iff (srst)
        ##1 freq_gain1 == {$past(gain1_high_q[3:0]), $past(gain1_low_byte)})
        else $error("gain one mismatch");
    a_gain2_concat: assert property (@(posedge mclk) disable iff (srst)
        ##1 freq_gain2 == {$past(gain2_high_q[3:0]), $past(gain2_low_byte)})
        else $error("gain two mismatch");
    a_attack_range: assert property (@(posedge mclk) disable iff (srst)
        peak_attack_shift >= 4'h1 && peak_attack_shift <= 4'h8)
        else $error("attack shift out of range");
    a_decay_range: assert property (@(posedge mclk) disable iff (srst)
        peak_decay_shift >= 4'h2 && peak_decay_shift <= 4'h9)
        else $error("decay shift out of range");

    // Sequencing checks
    a_restart_runs: assert property (@(posedge mclk) disable iff (srst)
        restart && state_q != LOOP_IDLE && gain_start_mode != START_OFF
        |=> gain_loop_active && !gain_loop_frozen)
        else $error("restart did not reactivate");
    a_never_freeze: assert property (@(posedge mclk) disable iff (srst)
        gain_freeze_mode == FRZ_NEVER && state_q == LOOP_RUN && !restart
        && gain_start_mode != START_OFF |=> state_q == LOOP_RUN)
        else $error("froze in stay-on mode");
    a_off_idle: assert property (@(posedge mclk) disable iff (srst)
        gain_start_mode == START_OFF |=> !gain_loop_active && !gain_loop_frozen)
        else $error("loop active with start off");
    // Reset, freeze and delay checks
    a_reset_vals: assert property (@(posedge mclk)
        $past(srst) |-> sf_cfg_q == RST_GAIN_SF_CFG && peak_q == RST_PEAK_FACT)
        else $error("reset values wrong");
    a_frozen_holds: assert property (@(posedge mclk) disable iff (srst)
        state_q == LOOP_FROZEN && !restart && !start_hit && gain_start_mode != START_OFF
        |=> state_q == LOOP_FROZEN)
        else $error("frozen state left without cause");
    a_manual_direct: assert property (@(posedge mclk) disable iff (srst)
        state_q == LOOP_RUN && gain_freeze_mode == FRZ_MANUAL && manual_gain_freeze_cmd
        && !restart && gain_start_mode != START_OFF |=> gain_loop_frozen)
        else $error("manual freeze missed");
    a_delay_entry: assert property (@(posedge mclk) disable iff (srst)
        delay_start && !restart && gain_start_mode != START_OFF |=> state_q == LOOP_DELAY)
        else $error("event freeze skipped the delay");
    a_delay_waits: assert property (@(posedge mclk) disable iff (srst)
        state_q == LOOP_DELAY && !delay_done && !restart && gain_start_mode != START_OFF
        |=> state_q == LOOP_DELAY)
        else $error("delay left early");
    a_delay_ends: assert property (@(posedge mclk) disable iff (srst)
        state_q == LOOP_DELAY && delay_done && !restart && gain_start_mode != START_OFF
        |=> gain_loop_frozen)
        else $error("delay end did not freeze");
    a_reset_outputs: assert property (@(posedge mclk)
        $past(srst) |-> !gain_loop_active && !gain_loop_frozen && rdata == RST_ZERO)
        else $error("outputs not cleared by reset");

    // Main scenarios: start, delayed freeze, manual freeze, restart
    c_direct_start: cover property (@(posedge mclk)
        state_q == LOOP_IDLE ##1 state_q == LOOP_RUN);
    c_event_start: cover property (@(posedge mclk)
        state_q == LOOP_IDLE && gain_start_mode == START_SIGREC ##1 state_q == LOOP_RUN);
    c_delay_freeze: cover property (@(posedge mclk)
        state_q == LOOP_DELAY ##1 state_q == LOOP_FROZEN);
    c_manual_freeze: cover property (@(posedge mclk)
        gain_freeze_mode == FRZ_MANUAL && state_q == LOOP_RUN ##1 state_q == LOOP_FROZEN);
    c_restart: cover property (@(posedge mclk)
        state_q == LOOP_FROZEN ##1 state_q == LOOP_RUN);
endmodule // loop_cfg
`default_nettype wire

// ==== loop_cfg_pkg.sv ====
// Package: register map, field layout, reset values and modes of the loop configuration slice
package loop_cfg_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] ADDR_GAIN1_LOW   = 8'h2d;
    localparam logic [7:0] ADDR_GAIN1_HIGH  = 8'h2e;
    localparam logic [7:0] ADDR_GAIN2_LOW   = 8'h2f;
    localparam logic [7:0] ADDR_GAIN2_HIGH  = 8'h30;
    localparam logic [7:0] ADDR_PEAK_FACT   = 8'h31;
    localparam logic [7:0] ADDR_GAIN_SF_CFG = 8'h32;
    localparam logic [7:0] ADDR_DELAY_RATIO = 8'h2b;
    localparam logic [7:0] ADDR_LOOP_STATUS = 8'h3f;
    localparam logic [7:0] ADDR_MAN_CMD     = 8'h3e;

    // ****************************************************************
    // Reset values and field masks
    // ****************************************************************
    localparam logic [7:0] RST_PEAK_FACT    = 8'h42;
    localparam logic [7:0] RST_GAIN_SF_CFG  = 8'h00;
    localparam logic [7:0] RST_ZERO         = 8'h00;
    localparam logic [7:0] MASK_NIBBLE      = 8'h0f;
    localparam logic [7:0] MASK_PEAK_FACT   = 8'h77;
    localparam logic [7:0] MASK_GAIN_SF_CFG = 8'h3f;
    localparam int         RESTART_BIT      = 5;
    localparam int         FREEZE_MSB       = 4;
    localparam int         FREEZE_LSB       = 2;
    localparam int         START_MSB        = 1;
    localparam int         START_LSB        = 0;
    localparam int         ATTACK_MSB       = 6;
    localparam int         ATTACK_LSB       = 4;
    localparam int         DECAY_MSB        = 2;
    localparam int         DECAY_LSB        = 0;
    localparam int         MAN_FREEZE_BIT   = 0;

    // Base period of the freeze delay: strobe period times this figure plus one
    localparam logic [1:0] DELAY_BASE_DIV   = 2'h3;  // counts 0..3, four ticks

    // ****************************************************************
    // Modes
    // ****************************************************************
    typedef enum logic [1:0]
    {
        START_OFF    = 2'b00,
        START_DIRECT = 2'b01,
        START_RSSI   = 2'b10,
        START_SIGREC = 2'b11
    } start_mode_t;

    typedef enum logic [2:0]
    {
        FRZ_NEVER  = 3'b000,
        FRZ_RSSI   = 3'b001,
        FRZ_SIGREC = 3'b010,
        FRZ_SYNC   = 3'b011,
        FRZ_MANUAL = 3'b100
    } freeze_mode_t;

    typedef enum logic [1:0]
    {
        LOOP_IDLE   = 2'b00,
        LOOP_RUN    = 2'b01,
        LOOP_DELAY  = 2'b10,
        LOOP_FROZEN = 2'b11
    } loop_state_t;

endpackage

// ==== freeze_delay.sv ====
// Freeze delay counter: base tick from predecimation strobe, scaled by ratio
`timescale 1ns/1ps
`default_nettype none
module freeze_delay
(
    input  wire logic       mclk,
    input  wire logic       srst,
    input  wire logic       strobe,
    input  wire logic       start,
    input  wire logic [7:0] ratio,
    output logic            done
);
    import loop_cfg_pkg::*;

    logic [1:0] base_q;
    logic [7:0] cnt_q;
    logic       busy_q;
    logic       tick;

    // Divide the strobe by four to make the base period
    assign tick = strobe && (base_q == DELAY_BASE_DIV);

    always_ff @(posedge mclk)
    begin
        if (srst || start)
            base_q <= 2'h0;
        else if (strobe)
            base_q <= base_q + 2'h1;
    end

    // Ratio zero gives an immediate finish, so no freeze waits forever
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            busy_q <= 1'b0;
            cnt_q  <= 8'h00;
            done   <= 1'b0;
        end
        else if (start)
        begin
            busy_q <= (ratio != 8'h00);
            cnt_q  <= ratio;
            done   <= (ratio == 8'h00);
        end
        else if (busy_q && tick)
        begin
            cnt_q  <= cnt_q - 8'h01;
            busy_q <= (cnt_q != 8'h01);
            done   <= (cnt_q == 8'h01);
        end
        else
            done <= 1'b0;
    end
endmodule // freeze_delay
`default_nettype wire

// ==== reg_port.sv ====
// Register port: write decode and read mux for the configuration slice
`timescale 1ns/1ps
`default_nettype none
module reg_port
(
    input  wire logic       mclk,
    input  wire logic       srst,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_stb,
    input  wire logic       rd_stb,
    input  wire logic [7:0] status,
    output logic [7:0]      rdata,
    output logic [7:0]      gain1_low_byte,
    output logic [7:0]      gain1_high_q,
    output logic [7:0]      gain2_low_byte,
    output logic [7:0]      gain2_high_q,
    output logic [7:0]      peak_q,
    output logic [7:0]      sf_cfg_q,
    output logic [7:0]      ratio_q,
    output logic            man_freeze
);
    import loop_cfg_pkg::*;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
        hit = wr_stb && (a == ref_a);
    endfunction

    // ****************************************************************
    // Writes
    // ****************************************************************
    // Unused bits are masked at write so reads show them as zero
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            gain1_low_byte <= RST_ZERO;
            gain1_high_q   <= RST_ZERO;
            gain2_low_byte <= RST_ZERO;
            gain2_high_q   <= RST_ZERO;
            peak_q         <= RST_PEAK_FACT;
            sf_cfg_q       <= RST_GAIN_SF_CFG;
            ratio_q        <= RST_ZERO;
        end
        else
        begin
            if (hit(addr, ADDR_GAIN1_LOW))   gain1_low_byte <= wdata;
            if (hit(addr, ADDR_GAIN1_HIGH))  gain1_high_q <= wdata & MASK_NIBBLE;
            if (hit(addr, ADDR_GAIN2_LOW))   gain2_low_byte <= wdata;
            if (hit(addr, ADDR_GAIN2_HIGH))  gain2_high_q <= wdata & MASK_NIBBLE;
            if (hit(addr, ADDR_PEAK_FACT))   peak_q <= wdata & MASK_PEAK_FACT;
            if (hit(addr, ADDR_GAIN_SF_CFG)) sf_cfg_q <= wdata & MASK_GAIN_SF_CFG;
            if (hit(addr, ADDR_DELAY_RATIO)) ratio_q <= wdata;
        end
    end

    // Manual freeze command is a self-clearing pulse
    always_ff @(posedge mclk)
    begin
        if (srst)
            man_freeze <= 1'b0;
        else
            man_freeze <= hit(addr, ADDR_MAN_CMD) && wdata[MAN_FREEZE_BIT];
    end

    // ****************************************************************
    // Reads
    // ****************************************************************
    // Data valid only in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge mclk)
    begin
        if (srst || !rd_stb)
            rdata <= 8'h00;
        else
        begin
            case (addr)
                ADDR_GAIN1_LOW:   rdata <= gain1_low_byte;
                ADDR_GAIN1_HIGH:  rdata <= gain1_high_q;
                ADDR_GAIN2_LOW:   rdata <= gain2_low_byte;
                ADDR_GAIN2_HIGH:  rdata <= gain2_high_q;
                ADDR_PEAK_FACT:   rdata <= peak_q;
                ADDR_GAIN_SF_CFG: rdata <= sf_cfg_q;
                ADDR_DELAY_RATIO: rdata <= ratio_q;
                ADDR_LOOP_STATUS: rdata <= status;
                default:          rdata <= 8'h00;
            endcase
        end
    end
endmodule // reg_port
`default_nettype wire

// ==== loop_cfg_tb.sv ====
// Self-checking testbench for the loop configuration slice
`timescale 1ns/1ps
`default_nettype none
module loop_cfg_tb;
    import loop_cfg_pkg::*;

    // ****************************************************************
    // Signals
    // ****************************************************************
    logic        mclk;
    logic        srst;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic        wr_stb;
    logic        rd_stb;
    logic [7:0]  rdata;
    logic        predec_strobe;
    logic [5:0]  ev;              // Pulses: rssi, sigrec, sync, channel, poll, hold exit
    logic        pll_hold_init_bit;
    logic        run_mode_slave;
    logic [11:0] freq_gain1;
    logic [11:0] freq_gain2;
    logic [3:0]  peak_attack_shift;
    logic [3:0]  peak_decay_shift;
    logic        gain_loop_active;
    logic        gain_loop_frozen;
    int          err_count;
    int          samples_checked;
    int          cycle_count;
    logic [23:0] rows [0:7];      // Address, write data, expected read back

    loop_cfg i_dut
    (
        .mclk              (mclk),
        .srst              (srst),
        .addr              (addr),
        .wdata             (wdata),
        .wr_stb            (wr_stb),
        .rd_stb            (rd_stb),
        .rdata             (rdata),
        .predec_strobe     (predec_strobe),
        .rssi_event        (ev[0]),
        .sigrec_event      (ev[1]),
        .sync_event        (ev[2]),
        .channel_change    (ev[3]),
        .poll_cfg_start    (ev[4]),
        .hold_exit         (ev[5]),
        .pll_hold_init_bit (pll_hold_init_bit),
        .run_mode_slave    (run_mode_slave),
        .freq_gain1        (freq_gain1),
        .freq_gain2        (freq_gain2),
        .peak_attack_shift (peak_attack_shift),
        .peak_decay_shift  (peak_decay_shift),
        .gain_loop_active  (gain_loop_active),
        .gain_loop_frozen  (gain_loop_frozen)
    );

    // Clock, 40 ns period
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // Hang guard: the whole run needs well under two thousand cycles
    always @(posedge mclk)
    begin
        cycle_count <= cycle_count + 1;
        if (cycle_count == 5000)
        begin
            err_count++;
            tally_and_finish();
        end
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic tally_and_finish();
        $display("Checked %0d values, %0d mismatches", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample there
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1;
        chk("rdata", {4'h0, exp}, {4'h0, rdata});
    endtask

    task automatic pulse(input int i);
        @(posedge mclk);
        ev[i] <= 1'b1;
        @(posedge mclk);
        ev[i] <= 1'b0;
    endtask

    // Strobes spaced four cycles apart, like a slow predecimation rate
    task automatic strb(input int n);
        repeat (n)
        begin
            @(posedge mclk);
            predec_strobe <= 1'b1;
            @(posedge mclk);
            predec_strobe <= 1'b0;
            repeat (2) @(posedge mclk);
        end
    endtask

    // Derived outputs lag the cause by two cycles; three leaves margin
    task automatic settle();
        repeat (3) @(posedge mclk);
        #1;
    endtask

    task automatic act(input logic exp);
        settle();
        chk("active", {11'h0, exp}, {11'h0, gain_loop_active});
    endtask

    task automatic frz(input logic exp);
        settle();
        chk("frozen", {11'h0, exp}, {11'h0, gain_loop_frozen});
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        srst = 1'b1;
        addr = 8'h00;
        wdata = 8'h00;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        predec_strobe = 1'b0;
        ev = 6'h00;
        pll_hold_init_bit = 1'b0;
        run_mode_slave = 1'b0;
        err_count = 0;
        samples_checked = 0;
        cycle_count = 0;
        rows = '{{ADDR_GAIN1_LOW, 8'ha5, 8'ha5}, {ADDR_GAIN1_HIGH, 8'hfb, 8'h0b},
                 {ADDR_GAIN2_LOW, 8'h3c, 8'h3c}, {ADDR_GAIN2_HIGH, 8'h97, 8'h07},
                 {ADDR_PEAK_FACT, 8'hff, 8'h77}, {ADDR_GAIN_SF_CFG, 8'hc0, 8'h00},
                 {8'h40, 8'hff, 8'h00}, {ADDR_LOOP_STATUS, 8'hff, 8'h00}};
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        #1;
        chk("attack", 12'h005, {8'h0, peak_attack_shift});
        chk("decay", 12'h004, {8'h0, peak_decay_shift});
        chk("active", 12'h000, {11'h0, gain_loop_active});
        rd(ADDR_PEAK_FACT, 8'h42);
        rd(ADDR_GAIN_SF_CFG, 8'h00);

        // Table rows: unused bits, unmapped and read-only places read 0
        for (int i = 0; i < 8; i++)
        begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16], rows[i][7:0]);
        end
        settle();
        chk("gain1", 12'hba5, freq_gain1);
        chk("gain2", 12'h73c, freq_gain2);

        // Every attack and decay code
        for (int n = 0; n < 8; n++)
        begin
            wr(ADDR_PEAK_FACT, {1'b0, n[2:0], 1'b0, n[2:0]});
            settle();
            chk("attack", n[11:0] + 12'h1, {8'h0, peak_attack_shift});
            chk("decay", n[11:0] + 12'h2, {8'h0, peak_decay_shift});
        end

        // Start modes: direct, then event starts ignore the other event
        act(1'b0);
        wr(ADDR_GAIN_SF_CFG, 8'h01);
        act(1'b1);
        rd(ADDR_LOOP_STATUS, 8'h01);
        for (int m = 2; m < 4; m++)
        begin
            wr(ADDR_GAIN_SF_CFG, 8'h00);
            act(1'b0);
            wr(ADDR_GAIN_SF_CFG, m[7:0]);
            pulse(3 - m);
            act(1'b0);
            pulse(m - 2);
            act(1'b1);
        end

        // Never-freeze mode ignores all events, then each event freeze with no delay
        wr(ADDR_GAIN_SF_CFG, 8'h01);
        pulse(0);
        pulse(1);
        pulse(2);
        frz(1'b0);
        wr(ADDR_DELAY_RATIO, 8'h00);
        for (int f = 1; f < 4; f++)
        begin
            wr(ADDR_GAIN_SF_CFG, 8'h00);
            wr(ADDR_GAIN_SF_CFG, {3'b000, f[2:0], 2'b01});
            frz(1'b0);
            pulse(f - 1);
            frz(1'b1);
        end

        // Freeze delay of ratio 2: eight strobes
        wr(ADDR_DELAY_RATIO, 8'h02);
        rd(ADDR_DELAY_RATIO, 8'h02);
        wr(ADDR_GAIN_SF_CFG, 8'h00);
        wr(ADDR_GAIN_SF_CFG, 8'h05);
        act(1'b1);
        pulse(0);
        strb(7);
        frz(1'b0);
        strb(2);
        frz(1'b1);

        // Manual freeze holds; restart disabled, then each restart source
        wr(ADDR_GAIN_SF_CFG, 8'h00);
        wr(ADDR_GAIN_SF_CFG, 8'h11);
        wr(ADDR_MAN_CMD, 8'h01);
        frz(1'b1);
        rd(ADDR_LOOP_STATUS, 8'h02);
        pulse(3);
        pulse(0);
        pulse(2);
        frz(1'b1);
        wr(ADDR_GAIN_SF_CFG, 8'h31);
        pulse(3);
        frz(1'b0);
        act(1'b1);
        wr(ADDR_MAN_CMD, 8'h01);
        frz(1'b1);
        pulse(4);
        frz(1'b0);
        wr(ADDR_MAN_CMD, 8'h01);
        @(posedge mclk);
        run_mode_slave <= 1'b1;
        pulse(5);
        frz(1'b1);
        @(posedge mclk);
        pll_hold_init_bit <= 1'b1;
        pulse(5);
        frz(1'b0);

        // Second reset in mid-run
        @(posedge mclk);
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        #1;
        chk("gain1", 12'h000, freq_gain1);
        chk("active", 12'h000, {11'h0, gain_loop_active});
        rd(ADDR_PEAK_FACT, 8'h42);
        rd(ADDR_GAIN_SF_CFG, 8'h00);
        tally_and_finish();
    end
endmodule // loop_cfg_tb
`default_nettype wire
